// ==== common/pin_config_defines.vh ====
// Register offsets, field positions and mode codes for the six multi-pins.
// Assumes inclusion by bare name from the design file.
`ifndef PIN_CONFIG_DEFINES_VH
`define PIN_CONFIG_DEFINES_VH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_FIRST_FAULT_OUTPUT_SEL_LO     8'h15
`define IDX_FIRST_FAULT_OUTPUT_SEL_HI     8'h16
`define IDX_SECOND_FAULT_OUTPUT_SEL_LO     8'h17
`define IDX_SECOND_FAULT_OUTPUT_SEL_HI     8'h18
`define IDX_PIN_OUTPUT_LEVELS 8'h1a
`define IDX_PIN_INPUT_LEVELS  8'h1b
`define IDX_PIN_MODE_LOW      8'h1c
`define IDX_PIN_MODE_MID      8'h1d
`define IDX_PIN_MODE_HIGH     8'h1e
`define IDX_TRACK_CTRL        8'h4e
`define IDX_TRACK_TIMING      8'h4f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_MODE_LOW          8'h00
`define RST_MODE_MID          8'h00
`define RST_MODE_HIGH         8'h00
`define RST_ZERO8             8'h00
`define MODE_HIGH_MASK        8'h03

// ----------------------------------------------------------------
// Field positions in the second dependency register
// ----------------------------------------------------------------
`define DEP_OV_BIT            4
`define DEP_UV_BIT            5
`define DEP_EW_BIT            6
`define DEP_POL_BIT           7

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define MODE_SPECIAL0         3'h0
`define MODE_PP_IO            3'h1
`define MODE_OD_IO            3'h2
`define MODE_PP_FAULT         3'h3
`define MODE_OD_FAULT         3'h4
`define MODE_IN_ONLY          3'h5
`define MODE_SPECIAL6         3'h6
`define MODE_SPECIAL7         3'h7

`endif

// ==== rtl/multi_function_pin_config.v ====
// Six multi-function pins: mode decode, pin drivers, fault combining,
// tracking control and an Avalon-MM register slave.
// Assumes pin inputs already synchronous to clk_in and a word bus.
//
// Operation
// - Three-bit mode per pin, packed across bytes
// - Pin 3 mode split across first two bytes
// - Pin 6 mode split; third byte top reserved
// - Code 000 tracking feedback on pins 1-4, pin 6 margin-disable
// - 001 push-pull IO, 010 open-drain IO
// - 011/100 fault outputs, push-pull or open-drain
// - 101 input only, never driven
// - 110 pin6 watchdog; 111 special pin inputs, pin6 power-up fault
// - Output register bits drive pins 1-6
// - Input register read-only, shows pin levels
// - Data registers not loaded from nonvolatile store
// - Combined fault active-low on any threshold
// - Dependency registers choose fault conditions, inputs
// - Selected inputs combine by logical OR
// - Per-channel pulldown enables in control upper nibble
// - Feedback follows ramp until power-good
// - Ramp slew and good threshold programmable
// - Each set dependency bit adds one input
// - Dependency top bit selects fault polarity
//
// The Avalon-MM slave port was left to the implementer.
module multi_function_pin_config #(
  parameter NUM_MON = 12,
  parameter NUM_PIN = 6
) (
  input  wire                 clk_in,
  input  wire                 reset_in,
  input  wire [7:0]           avm_address_in,
  input  wire                 avm_read_in,
  input  wire                 avm_write_in,
  input  wire [31:0]          avm_writedata_in,
  input  wire [3:0]           avm_byteenable_in,
  output reg  [31:0]          avm_readdata_out,
  output reg                  avm_waitrequest_out,
  output reg  [1:0]           avm_response_out,
  input  wire [NUM_PIN-1:0]   pin_level_in,
  output reg  [NUM_PIN-1:0]   pin_drive_out,
  output reg  [NUM_PIN-1:0]   pin_oe_out,
  input  wire [NUM_MON-1:0]   mon_overvoltage_in,
  input  wire [NUM_MON-1:0]   mon_undervoltage_in,
  input  wire [NUM_MON-1:0]   mon_early_warning_in,
  input  wire [3:0]           ramp_above_feedback_in,
  input  wire [3:0]           power_good_in,
  output reg  [3:0]           tracking_feedback_out,
  output reg  [3:0]           supply_enable_raise_out,
  output reg  [3:0]           pulldown_enable_out,
  output reg  [3:0]           ramp_slew_out,
  output reg  [3:0]           good_threshold_out,
  output reg                  margin_disable_input_out,
  output reg                  margin_raise_input_out,
  output reg                  margin_lower_input_out,
  output reg                  manual_reset_input_out,
  output reg                  watchdog_kick_input_out,
  input  wire                 watchdog_expired_in,
  input  wire                 powerup_fault_in
);

`include "pin_config_defines.vh"

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] pin_output_levels_r;
  reg [7:0] pin_input_levels_r;
  reg [7:0] pin_mode_select_low_r;
  reg [7:0] pin_mode_select_mid_r;
  reg [7:0] pin_mode_select_high_r;
  reg [7:0] first_fault_output_sel_lo_r;
  reg [7:0] first_fault_output_sel_hi_r;
  reg [7:0] second_fault_output_sel_lo_r;
  reg [7:0] second_fault_output_sel_hi_r;
  reg [7:0] track_ctrl_r;
  reg [7:0] track_timing_r;
  reg       bus_done_r;

  // Merge a byte with write data under byte-lane 0
  function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input       lane;
    begin
      merge_byte = lane ? new_val : old_val;
    end
  endfunction

  // Fault condition for one selector pair: OR of selected inputs
  function fault_hit;
    input [7:0]         sel_lo;
    input [7:0]         sel_hi;
    input [NUM_MON-1:0] ov;
    input [NUM_MON-1:0] uv;
    input [NUM_MON-1:0] ew;
    reg   [11:0]        sel;
    begin
      sel = {sel_hi[3:0], sel_lo};
      fault_hit = (sel_hi[`DEP_OV_BIT] && |(sel & ov[11:0])) ||
                  (sel_hi[`DEP_UV_BIT] && |(sel & uv[11:0])) ||
                  (sel_hi[`DEP_EW_BIT] && |(sel & ew[11:0]));
    end
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire [2:0] mode [0:NUM_PIN-1];
  assign mode[0] = pin_mode_select_low_r[2:0];
  assign mode[1] = pin_mode_select_low_r[5:3];
  assign mode[2] = {pin_mode_select_mid_r[0],
                    pin_mode_select_low_r[7:6]};
  assign mode[3] = pin_mode_select_mid_r[3:1];
  assign mode[4] = pin_mode_select_mid_r[6:4];
  assign mode[5] = {pin_mode_select_high_r[1:0],
                    pin_mode_select_mid_r[7]};

  wire any_fault;
  wire first_fault_output_active;
  wire second_fault_output_active;
  assign any_fault = |mon_overvoltage_in | |mon_undervoltage_in |
                     |mon_early_warning_in;
  assign first_fault_output_active = fault_hit(first_fault_output_sel_lo_r, first_fault_output_sel_hi_r,
                                   mon_overvoltage_in,
                                   mon_undervoltage_in,
                                   mon_early_warning_in);
  assign second_fault_output_active = fault_hit(second_fault_output_sel_lo_r, second_fault_output_sel_hi_r,
                                   mon_overvoltage_in,
                                   mon_undervoltage_in,
                                   mon_early_warning_in);

  // Logic level each pin wants, before the driver style is applied
  reg [NUM_PIN-1:0] want_level;
  reg [NUM_PIN-1:0] push_pull;
  reg [NUM_PIN-1:0] open_drain;
  integer i;
  always @* begin
    want_level = {NUM_PIN{1'b1}};
    push_pull  = {NUM_PIN{1'b0}};
    open_drain = {NUM_PIN{1'b0}};
    for (i = 0; i < NUM_PIN; i = i + 1) begin
      case (mode[i])
        `MODE_PP_IO: begin
          push_pull[i]  = 1'b1;
          want_level[i] = pin_output_levels_r[i];
        end
        `MODE_OD_IO: begin
          open_drain[i] = 1'b1;
          want_level[i] = pin_output_levels_r[i];
        end
        `MODE_PP_FAULT, `MODE_OD_FAULT: begin
          push_pull[i]  = (mode[i] == `MODE_PP_FAULT);
          open_drain[i] = (mode[i] == `MODE_OD_FAULT);
          if (i == 4) begin
            want_level[i] = first_fault_output_active ^
                            ~first_fault_output_sel_hi_r[`DEP_POL_BIT];
          end else if (i == 5) begin
            want_level[i] = second_fault_output_active ^
                            ~second_fault_output_sel_hi_r[`DEP_POL_BIT];
          end else begin
            want_level[i] = ~any_fault;
          end
        end
        `MODE_SPECIAL6: begin
          if (i == 5) begin
            open_drain[i] = 1'b1;
            want_level[i] = ~watchdog_expired_in;
          end
        end
        `MODE_SPECIAL7: begin
          if (i == 5) begin
            open_drain[i] = 1'b1;
            want_level[i] = ~powerup_fault_in;
          end
        end
        default: begin
          want_level[i] = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and decoded input functions
  // ----------------------------------------------------------------
  // Open-drain only pulls low; a high is a released pin
  wire [NUM_PIN-1:0] oe_nxt;
  wire [NUM_PIN-1:0] drive_nxt;
  assign oe_nxt    = push_pull | (open_drain & ~want_level);
  assign drive_nxt = push_pull & want_level;

  wire [3:0] track_sel;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_track
      assign track_sel[g] = (mode[g] == `MODE_SPECIAL0);
    end
  endgenerate

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_drive_out            <= {NUM_PIN{1'b0}};
      pin_oe_out               <= {NUM_PIN{1'b0}};
      tracking_feedback_out    <= 4'h0;
      supply_enable_raise_out  <= 4'h0;
      pulldown_enable_out      <= 4'h0;
      ramp_slew_out            <= 4'h0;
      good_threshold_out       <= 4'h0;
      margin_disable_input_out <= 1'b0;
      margin_raise_input_out   <= 1'b0;
      margin_lower_input_out   <= 1'b0;
      manual_reset_input_out   <= 1'b0;
      watchdog_kick_input_out  <= 1'b0;
      pin_input_levels_r       <= `RST_ZERO8;
    end else begin
      pin_drive_out <= drive_nxt;
      pin_oe_out    <= oe_nxt;
      tracking_feedback_out <= track_sel & pin_level_in[3:0];
      // Raise the enable while the ramp leads and power is not good
      supply_enable_raise_out <= track_sel & ramp_above_feedback_in &
                                 ~power_good_in;
      pulldown_enable_out <= track_sel & track_ctrl_r[7:4];
      ramp_slew_out       <= track_timing_r[3:0];
      good_threshold_out  <= track_timing_r[7:4];
      margin_disable_input_out <= (mode[5] == `MODE_SPECIAL0) &
                                  pin_level_in[5];
      margin_raise_input_out <= (mode[1] == `MODE_SPECIAL7) &
                                pin_level_in[1];
      margin_lower_input_out <= (mode[2] == `MODE_SPECIAL7) &
                                pin_level_in[2];
      manual_reset_input_out <= (mode[3] == `MODE_SPECIAL7) &
                                pin_level_in[3];
      watchdog_kick_input_out <= (mode[4] == `MODE_SPECIAL7) &
                                 pin_level_in[4];
      pin_input_levels_r <= {2'b00, pin_level_in};
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  // Reserved codes are stored as written; software must avoid them
  wire       req;
  wire       wr_go;
  wire       lane0;
  wire [7:0] wd;
  assign req   = (avm_read_in | avm_write_in) & ~bus_done_r;
  assign wr_go = avm_write_in & ~bus_done_r;
  assign lane0 = avm_byteenable_in[0];
  assign wd    = avm_writedata_in[7:0];

  reg [7:0] rd_byte;
  reg       hit;
  always @* begin
    hit = 1'b1;
    case (avm_address_in)
      `IDX_FIRST_FAULT_OUTPUT_SEL_LO:     rd_byte = first_fault_output_sel_lo_r;
      `IDX_FIRST_FAULT_OUTPUT_SEL_HI:     rd_byte = first_fault_output_sel_hi_r;
      `IDX_SECOND_FAULT_OUTPUT_SEL_LO:     rd_byte = second_fault_output_sel_lo_r;
      `IDX_SECOND_FAULT_OUTPUT_SEL_HI:     rd_byte = second_fault_output_sel_hi_r;
      `IDX_PIN_OUTPUT_LEVELS: rd_byte = {2'b00, pin_output_levels_r[5:0]};
      `IDX_PIN_INPUT_LEVELS:  rd_byte = pin_input_levels_r;
      `IDX_PIN_MODE_LOW:      rd_byte = pin_mode_select_low_r;
      `IDX_PIN_MODE_MID:      rd_byte = pin_mode_select_mid_r;
      `IDX_PIN_MODE_HIGH:     rd_byte = pin_mode_select_high_r;
      `IDX_TRACK_CTRL:        rd_byte = track_ctrl_r;
      `IDX_TRACK_TIMING:      rd_byte = track_timing_r;
      default: begin
        rd_byte = 8'h00;
        hit     = 1'b0;
      end
    endcase
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_done_r             <= 1'b0;
      avm_waitrequest_out    <= 1'b1;
      avm_readdata_out       <= 32'h0000_0000;
      avm_response_out       <= 2'h0;
      // Data registers reset to zero, not from nonvolatile store
      pin_output_levels_r    <= `RST_ZERO8;
      pin_mode_select_low_r  <= `RST_MODE_LOW;
      pin_mode_select_mid_r  <= `RST_MODE_MID;
      pin_mode_select_high_r <= `RST_MODE_HIGH;
      first_fault_output_sel_lo_r        <= `RST_ZERO8;
      first_fault_output_sel_hi_r        <= `RST_ZERO8;
      second_fault_output_sel_lo_r        <= `RST_ZERO8;
      second_fault_output_sel_hi_r        <= `RST_ZERO8;
      track_ctrl_r           <= `RST_ZERO8;
      track_timing_r         <= `RST_ZERO8;
    end else begin
      bus_done_r          <= req;
      avm_waitrequest_out <= ~req;
      avm_readdata_out    <= {24'h000000, rd_byte};
      avm_response_out    <= hit ? 2'h0 : 2'h2;
      if (wr_go) begin
        case (avm_address_in)
          `IDX_PIN_OUTPUT_LEVELS: pin_output_levels_r <=
            merge_byte(pin_output_levels_r, {2'b00, wd[5:0]}, lane0);
          `IDX_PIN_MODE_LOW: pin_mode_select_low_r <=
            merge_byte(pin_mode_select_low_r, wd, lane0);
          `IDX_PIN_MODE_MID: pin_mode_select_mid_r <=
            merge_byte(pin_mode_select_mid_r, wd, lane0);
          `IDX_PIN_MODE_HIGH: pin_mode_select_high_r <=
            merge_byte(pin_mode_select_high_r,
                       wd & `MODE_HIGH_MASK, lane0);
          `IDX_FIRST_FAULT_OUTPUT_SEL_LO: first_fault_output_sel_lo_r <=
            merge_byte(first_fault_output_sel_lo_r, wd, lane0);
          `IDX_FIRST_FAULT_OUTPUT_SEL_HI: first_fault_output_sel_hi_r <=
            merge_byte(first_fault_output_sel_hi_r, wd, lane0);
          `IDX_SECOND_FAULT_OUTPUT_SEL_LO: second_fault_output_sel_lo_r <=
            merge_byte(second_fault_output_sel_lo_r, wd, lane0);
          `IDX_SECOND_FAULT_OUTPUT_SEL_HI: second_fault_output_sel_hi_r <=
            merge_byte(second_fault_output_sel_hi_r, wd, lane0);
          `IDX_TRACK_CTRL: track_ctrl_r <=
            merge_byte(track_ctrl_r, wd, lane0);
          `IDX_TRACK_TIMING: track_timing_r <=
            merge_byte(track_timing_r, wd, lane0);
          default: begin
            track_ctrl_r <= track_ctrl_r;
          end
        endcase
      end
    end
  end

endmodule // multi_function_pin_config

// ==== tb/pin_board_model.sv ====
// Board side of the six pins: pull-ups and external drivers.
// Assumes the design's enable is high while it drives a pin.
module pin_board_model (
  input  wire logic [5:0] pin_drive_in,
  input  wire logic [5:0] pin_oe_in,
  input  wire logic [5:0] ext_drive_in,
  input  wire logic [5:0] ext_oe_in,
  output logic      [5:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up, so a released pin never reads a stale value
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      level_out[i] = pin_oe_in[i] ? pin_drive_in[i] :
                     ext_oe_in[i] ? ext_drive_in[i] : 1'b1;
    end
  end
endmodule // pin_board_model

// ==== tb/pin_config_asserts.sv ====
// Checker for the pin block: bus timing, decode and tracking relations.
// Assumes binding to the design top, one clock domain.
`include "pin_config_defines.vh"
module pin_config_asserts #(
  parameter NUM_PIN = 6
) (
  input wire logic               clk_in,
  input wire logic               reset_in,
  input wire logic [7:0]         avm_address_in,
  input wire logic               avm_read_in,
  input wire logic               avm_write_in,
  input wire logic [31:0]        avm_readdata_out,
  input wire logic               avm_waitrequest_out,
  input wire logic [1:0]         avm_response_out,
  input wire logic [NUM_PIN-1:0] pin_oe_out,
  input wire logic [3:0]         tracking_feedback_out,
  input wire logic [3:0]         pulldown_enable_out,
  input wire logic [3:0]         supply_enable_raise_out,
  input wire logic [3:0]         ramp_above_feedback_in,
  input wire logic [3:0]         power_good_in,
  input wire logic [3:0]         ramp_slew_out,
  input wire logic [3:0]         good_threshold_out,
  input wire logic               margin_raise_input_out,
  input wire logic               manual_reset_input_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire logic req = avm_read_in | avm_write_in;
  wire logic [7:0] a = avm_address_in;
  wire logic map = (a >= 8'h15 && a <= 8'h18) || (a >= 8'h1a && a <= 8'h1e)
                   || a == 8'h4e || a == 8'h4f;
  // ----------------------------------------------------------------
  // Bus
  // ----------------------------------------------------------------
  sequence s_taken;
    req && avm_waitrequest_out && !$past(req);
  endsequence
  sequence s_done;
    req && !avm_waitrequest_out;
  endsequence
  property p_answer;
    s_taken |=> !avm_waitrequest_out;
  endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_stand;
    !avm_waitrequest_out |=> avm_waitrequest_out;
  endproperty
  a_stand: assert property (p_stand) else $error("long answer");
  property p_resp;
    s_done |-> avm_response_out == (map ? 2'b00 : 2'b10);
  endproperty
  a_resp: assert property (p_resp) else $error("bad response");
  property p_rdata;
    s_done ##0 avm_read_in |-> avm_readdata_out[31:8] == 24'h0 &&
      (map || avm_readdata_out == 32'h0) &&
      (a[7:1] != 7'h0d || avm_readdata_out[7:6] == 2'b00);
  endproperty
  a_rdata: assert property (p_rdata) else $error("bad read data");
  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  property p_track;
    (tracking_feedback_out & pin_oe_out[3:0]) == 4'h0;
  endproperty
  a_track: assert property (p_track) else $error("feedback driven");
  property p_spec;
    margin_raise_input_out | manual_reset_input_out |->
      !(margin_raise_input_out & pin_oe_out[1]) &&
      !(manual_reset_input_out & pin_oe_out[3]);
  endproperty
  a_spec: assert property (p_spec) else $error("input driven");
  property p_pull;
    (pulldown_enable_out & pin_oe_out[3:0]) == 4'h0;
  endproperty
  a_pull: assert property (p_pull) else $error("pulldown on output");
  property p_raise;
    (supply_enable_raise_out &
      ~$past(ramp_above_feedback_in & ~power_good_in)) == 4'h0;
  endproperty
  a_raise: assert property (p_raise) else $error("bad raise");
  property p_timing;
    $changed({good_threshold_out, ramp_slew_out}) |->
      $past(avm_write_in && a == `IDX_TRACK_TIMING, 2);
  endproperty
  a_timing: assert property (p_timing) else $error("timing moved");
endmodule // pin_config_asserts
bind multi_function_pin_config pin_config_asserts #(.NUM_PIN(NUM_PIN))
  i_asserts (.clk_in, .reset_in, .avm_address_in, .avm_read_in,
  .avm_write_in, .avm_readdata_out, .avm_waitrequest_out, .avm_response_out,
  .pin_oe_out, .tracking_feedback_out, .pulldown_enable_out,
  .supply_enable_raise_out, .ramp_above_feedback_in, .power_good_in,
  .ramp_slew_out, .good_threshold_out, .margin_raise_input_out,
  .manual_reset_input_out);

// ==== tb/testbench.sv ====
// Random self-checking bench for the six multi-function pins.
// Assumes the board model and the bound checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, reset_in = 1'b1, avm_read_in = 1'b0;
  logic avm_write_in = 1'b0, wd = 1'b0, pu = 1'b0;
  logic [7:0] avm_address_in = 8'h00;
  logic [31:0] avm_writedata_in = 32'h0;
  logic [3:0] avm_byteenable_in = 4'h1, ramp = 4'h0, pg = 4'h0;
  logic [11:0] ov = 12'h0, uv = 12'h0, ew = 12'h0;
  logic [5:0] e_dr = 6'h0, e_oe = 6'h0;
  wire [31:0] avm_readdata_out;
  wire [1:0] avm_response_out;
  wire avm_waitrequest_out, m_dis, m_up, m_dn, m_rst, kick;
  wire [5:0] lvl, pin_drive_out, pin_oe_out;
  wire [3:0] fb, se, pd, slew, thr;
  int bad_count = 0, n_tests = 0;
  integer seed = 32'hd1bcbbdf;
  always #4 clk_in = ~clk_in;
  multi_function_pin_config i_dut (.clk_in, .reset_in, .avm_address_in,
    .avm_read_in, .avm_write_in, .avm_writedata_in, .avm_byteenable_in,
    .avm_readdata_out, .avm_waitrequest_out, .avm_response_out,
    .pin_level_in(lvl), .pin_drive_out, .pin_oe_out, .mon_overvoltage_in(ov),
    .mon_undervoltage_in(uv), .mon_early_warning_in(ew),
    .ramp_above_feedback_in(ramp), .power_good_in(pg),
    .tracking_feedback_out(fb), .supply_enable_raise_out(se),
    .pulldown_enable_out(pd), .ramp_slew_out(slew), .good_threshold_out(thr),
    .margin_disable_input_out(m_dis), .margin_raise_input_out(m_up),
    .margin_lower_input_out(m_dn), .manual_reset_input_out(m_rst),
    .watchdog_kick_input_out(kick), .watchdog_expired_in(wd),
    .powerup_fault_in(pu));
  pin_board_model i_board (.pin_drive_in(pin_drive_out),
    .pin_oe_in(pin_oe_out), .ext_drive_in(e_dr), .ext_oe_in(e_oe),
    .level_out(lvl));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until waitrequest is seen low
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d, logic [3:0] be,
                     output logic [31:0] rd, output logic [1:0] rsp);
    int n;
    @(posedge clk_in);
    avm_address_in <= a;
    avm_writedata_in <= {24'h0, d};
    avm_byteenable_in <= be;
    avm_write_in <= w;
    avm_read_in <= ~w;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avm_waitrequest_out !== 1'b0 && n < 64);
    if (n >= 64) chk("bus answer", 1, 0);
    rd = avm_readdata_out;
    rsp = avm_response_out;
    avm_write_in <= 1'b0;
    avm_read_in <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [31:0] r;
    logic [1:0] s;
    bus(1'b1, a, d, 4'h1, r, s);
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e, logic [1:0] es);
    logic [31:0] r;
    logic [1:0] s;
    bus(1'b0, a, 8'h00, 4'h1, r, s);
    chk($sformatf("reg %h", a), {22'h0, es, e},
        {21'h0, |r[31:8], s, r[7:0]});
  endtask
  function automatic logic flt(logic [7:0] lo, logic [7:0] hi);
    logic x;
    x = |({hi[3:0], lo} & ((hi[4] ? ov : 12'h0) | (hi[5] ? uv : 12'h0) |
        (hi[6] ? ew : 12'h0)));
    return hi[7] ? x : ~x;
  endfunction
  function automatic logic [1:0] pexp(int p, logic [2:0] m, logic ob,
                                      logic lv);
    case (m)
      3'h1: return {1'b1, ob};
      3'h2: return {~ob, 1'b0};
      3'h3: return {1'b1, lv};
      3'h4: return {~lv, 1'b0};
      3'h6: return {p == 5 && wd, 1'b0};
      3'h7: return {p == 5 && pu, 1'b0};
      default: return 2'b00;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // One random configuration with board stimulus
  // ----------------------------------------------------------------
  task automatic run_case(int it);
    logic [2:0] m [6];
    logic [7:0] r [9];
    logic [5:0] xo, xd, xl, t;
    logic [1:0] e;
    for (int p = 0; p < 6; p++) begin
      m[p] = it == 0 ? 3'h2 : 3'($random(seed));
      if ((m[p] == 6 && p < 5) || (m[p] == 7 && p == 0) ||
          (m[p] == 0 && p == 4)) m[p] = 3'h5;
    end
    foreach (r[i]) r[i] = 8'($random(seed));
    if (it == 0) r[4] = 8'hff;
    r[5] = {m[2][1:0], m[1], m[0]};
    r[6] = {m[5][0], m[4], m[3], m[2][2]};
    r[7] = {r[7][7:2], m[5][2:1]};
    foreach (r[i]) wr(i < 4 ? 8'h15 + i : i == 4 ? 8'h1a :
                      i < 8 ? 8'h17 + i : 8'h4e,
                      i == 8 ? r[3] : r[i]);
    wr(8'h4f, r[2]);
    wr(8'h1b, 8'h2a);
    @(posedge clk_in);
    ov <= r[0][0] ? 12'h0 : 12'($random(seed) & $random(seed));
    uv <= 12'($random(seed) & $random(seed) & $random(seed));
    ew <= 12'($random(seed) & $random(seed) & $random(seed));
    {wd, pu, ramp, pg} <= 10'($random(seed));
    @(posedge clk_in);
    for (int p = 0; p < 6; p++) begin
      e = pexp(p, m[p], r[4][p], p < 4 ? ~(|{ov, uv, ew}) :
               p == 4 ? flt(r[0], r[1]) : flt(r[2], r[3]));
      {xo[p], xd[p]} = e;
    end
    t = 6'($random(seed));
    e_oe <= ~xo & t;
    e_dr <= 6'($random(seed));
    repeat (4) @(posedge clk_in);
    for (int p = 0; p < 6; p++) xl[p] = xo[p] ? xd[p] : e_oe[p] ? e_dr[p] : 1;
    for (int p = 0; p < 4; p++) t[p] = m[p] == 3'h0;
    chk("pin enable", xo, pin_oe_out);
    chk("pin drive", xd, pin_drive_out & xo);
    chk("feedback", t[3:0] & xl[3:0], fb);
    chk("pulldown", t[3:0] & r[3][7:4], pd);
    chk("raise", t[3:0] & ramp & ~pg, se);
    chk("slew", r[2], {thr, slew});
    chk("specials", {m[5] == 0 && xl[5], m[1] == 7 && xl[1],
        m[2] == 7 && xl[2], m[3] == 7 && xl[3], m[4] == 7 && xl[4]},
        {m_dis, m_up, m_dn, m_rst, kick});
    rdc(8'h1b, {2'b00, xl}, 2'b00);
    rdc(8'h1a, r[4] & 8'h3f, 2'b00);
    rdc(8'h1c, r[5], 2'b00);
    rdc(8'h1d, r[6], 2'b00);
    rdc(8'h1e, r[7] & 8'h03, 2'b00);
  endtask
  initial begin
    #200000;
    chk("watchdog", 1, 0);
    test_done();
  end
  initial begin
    logic [31:0] r0;
    logic [1:0]  s0;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(8'h15 + i, 8'h00, 2'b00);
    rdc(8'h1a, 8'h00, 2'b00);
    rdc(8'h1e, 8'h00, 2'b00);
    rdc(8'h20, 8'h00, 2'b10);
    rdc(8'hff, 8'h00, 2'b10);
    wr(8'h1a, 8'h3f);
    rdc(8'h1a, 8'h3f & 8'h3f, 2'b00);
    // Lane 0 disabled: the write must be ignored
    bus(1'b1, 8'h1a, 8'h00, 4'h0, r0, s0);
    rdc(8'h1a, 8'h3f, 2'b00);
    $display("Register reset and decode test done");
    for (int it = 0; it < 40; it++) run_case(it);
    $display("Random pin configuration test done");
    test_done();
  end
endmodule // testbench
